// file: verilog/i2c_gpio_pkg.sv
// Shared constants and types for the two-wire GPIO expander
package i2c_gpio_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;

    // ==========================================================
    // Protocol constants
    localparam logic [ADDR_W-1:0] DEFAULT_ADDR = 7'h00;
    localparam logic [CNT_W-1:0] BYTE_BITS = 4'h8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic RW_READ = 1'b1;
    localparam logic ACK_LEVEL = 1'b0;
    localparam logic PIN_LOW = 1'b0;
    localparam logic OE_RELEASED = 1'b1;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] GPO_RESET = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

    // ==========================================================
    // Bus-side sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK,
        ST_IGNORE
    } link_state_e;

endpackage

// file: verilog/cdc_word_toggle.sv
// Toggle-handshake crossing that loads a whole word into the destination domain
`timescale 1ns/1ns
`default_nettype none

module cdc_word_toggle #(
    parameter int W = 8
) (
    input wire logic clk, // Destination clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic srcToggle, // Flips once per new word, source domain
    input wire logic [W-1:0] srcWord, // Held stable by the source after the flip
    output logic [W-1:0] dstWord // Registered word, all bits change at once
);

    // ==========================================================
    // Synchroniser and edge detect
    logic tglMeta_q;
    logic tglSync_q;
    logic tglSeen_q;
    logic [W-1:0] word_q;
    logic [W-1:0] word_d;
    logic newWord;

    // Only the second and third stages feed the comparator
    assign newWord = tglSync_q ^ tglSeen_q;

    // Word is sampled only once the toggle has settled, so it cannot tear
    always_comb begin
        word_d = word_q;
        if (newWord) begin
            word_d = srcWord;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tglMeta_q <= 1'b0;
            tglSync_q <= 1'b0;
            tglSeen_q <= 1'b0;
            word_q <= '0;
        end else begin
            tglMeta_q <= srcToggle;
            tglSync_q <= tglMeta_q;
            tglSeen_q <= tglSync_q;
            word_q <= word_d;
        end
    end

    assign dstWord = word_q;

endmodule

`default_nettype wire

// file: verilog/i2c_gpio_expander.sv
// Two-wire bus slave giving eight general purpose inputs and eight outputs
`timescale 1ns/1ns
`default_nettype none

module i2c_gpio_expander #(
    parameter logic [i2c_gpio_pkg::ADDR_W-1:0] OWN_ADDR = i2c_gpio_pkg::DEFAULT_ADDR,
    parameter int GP_W = i2c_gpio_pkg::DATA_W
) (
    input wire logic clk, // System clock, 250 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic linkClk, // Bus sampling clock for the link side
    input wire logic sclIn, // Bus clock line level
    output logic sclOut, // Bus clock drive value, always low
    output logic sclOeN, // Bus clock enable, low drives, always released
    input wire logic sdaIn, // Bus data line level
    output logic sdaOut, // Bus data drive value, always low
    output logic sdaOeN, // Bus data enable, low pulls the line low
    input wire logic [GP_W-1:0] gpIn, // General purpose input pins
    output logic [GP_W-1:0] gpOut // General purpose output pins
);

    // ==========================================================
    // Reset carried into the link domain
    // Held two link edges; sys_rst must stay high for several link periods
    logic linkRstMeta_q;
    logic linkRstMeta_d;
    logic linkRst_q;
    logic linkRst_d;

    // Plain two-stage chain; it has no reset of its own because it is the reset
    always_comb begin
        linkRstMeta_d = sys_rst;
        linkRst_d = linkRstMeta_q;
    end

    // Only the second stage is read by the link logic
    always_ff @(posedge linkClk) begin
        linkRstMeta_q <= linkRstMeta_d;
        linkRst_q <= linkRst_d;
    end

    // ==========================================================
    // Pin synchronisers in the link domain
    logic sclMeta_q;
    logic sclMeta_d;
    logic sclSync_q;
    logic sclSync_d;
    logic sclDly_q;
    logic sclDly_d;
    logic sdaMeta_q;
    logic sdaMeta_d;
    logic sdaSync_q;
    logic sdaSync_d;
    logic sdaDly_q;
    logic sdaDly_d;
    logic [GP_W-1:0] gpiMeta_q;
    logic [GP_W-1:0] gpiMeta_d;
    logic [GP_W-1:0] gpiSync_q;
    logic [GP_W-1:0] gpiSync_d;

    // Two stages before use; a third stage gives the edge history
    // Lines reset to their idle high level so no false edge follows reset
    always_comb begin
        sclMeta_d = sclIn;
        sclSync_d = sclMeta_q;
        sclDly_d = sclSync_q;
        sdaMeta_d = sdaIn;
        sdaSync_d = sdaMeta_q;
        sdaDly_d = sdaSync_q;
        gpiMeta_d = gpIn;
        gpiSync_d = gpiMeta_q;
        if (linkRst_q) begin
            sclMeta_d = 1'b1;
            sclSync_d = 1'b1;
            sclDly_d = 1'b1;
            sdaMeta_d = 1'b1;
            sdaSync_d = 1'b1;
            sdaDly_d = 1'b1;
            gpiMeta_d = '0;
            gpiSync_d = '0;
        end
    end

    // Registers only; the reset choice is made above
    always_ff @(posedge linkClk) begin
        sclMeta_q <= sclMeta_d;
        sclSync_q <= sclSync_d;
        sclDly_q <= sclDly_d;
        sdaMeta_q <= sdaMeta_d;
        sdaSync_q <= sdaSync_d;
        sdaDly_q <= sdaDly_d;
        gpiMeta_q <= gpiMeta_d;
        gpiSync_q <= gpiSync_d;
    end

    // ==========================================================
    // Bus events
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    // Start and stop are data edges while the clock stays high
    // Each event lasts one link cycle and shows 1-2 cycles after the pin moves
    // A master that moves data within that window of a clock edge is not supported
    assign sclRise = sclSync_q & ~sclDly_q;
    assign sclFall = ~sclSync_q & sclDly_q;
    assign startCond = sclSync_q & sclDly_q & sdaDly_q & ~sdaSync_q;
    assign stopCond = sclSync_q & sclDly_q & ~sdaDly_q & sdaSync_q;

    // ==========================================================
    // Bus sequencer state
    i2c_gpio_pkg::link_state_e state_q;
    i2c_gpio_pkg::link_state_e state_d;
    logic [i2c_gpio_pkg::CNT_W-1:0] cnt_q;
    logic [i2c_gpio_pkg::CNT_W-1:0] cnt_d;
    logic [GP_W-1:0] rxSh_q;
    logic [GP_W-1:0] rxSh_d;
    logic [GP_W-1:0] txSh_q;
    logic [GP_W-1:0] txSh_d;
    logic rw_q;
    logic rw_d;
    logic drvLow_q;
    logic drvLow_d;
    logic [GP_W-1:0] wrByte_q;
    logic [GP_W-1:0] wrByte_d;
    logic wrTgl_q;
    logic wrTgl_d;
    logic addrHit;

    // Top seven bits of the first byte are the address, the last the direction
    assign addrHit = (rxSh_q[GP_W-1:1] == OWN_ADDR);

    // Data changes only at clock falls, so it is stable while the clock is high
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        rxSh_d = rxSh_q;
        txSh_d = txSh_q;
        rw_d = rw_q;
        drvLow_d = drvLow_q;
        wrByte_d = wrByte_q;
        wrTgl_d = wrTgl_q;
        if (stopCond) begin
            state_d = i2c_gpio_pkg::ST_IDLE;
            drvLow_d = 1'b0;
        end else if (startCond) begin
            // A repeated start ends the running transfer as well
            state_d = i2c_gpio_pkg::ST_ADDR;
            cnt_d = i2c_gpio_pkg::CNT_ZERO;
            drvLow_d = 1'b0;
        end else begin
            unique case (state_q)
                // Ignore also covers a read that the master ended with no acknowledge
                i2c_gpio_pkg::ST_IDLE, i2c_gpio_pkg::ST_IGNORE: begin
                    drvLow_d = 1'b0;
                end
                i2c_gpio_pkg::ST_ADDR: begin
                    if (sclRise) begin
                        rxSh_d = {rxSh_q[GP_W-2:0], sdaSync_q};
                        cnt_d = cnt_q + i2c_gpio_pkg::CNT_ONE;
                    end
                    if (sclFall && cnt_q == i2c_gpio_pkg::BYTE_BITS) begin
                        if (addrHit) begin
                            state_d = i2c_gpio_pkg::ST_ADDR_ACK;
                            drvLow_d = 1'b1;
                            rw_d = rxSh_q[0];
                            // Inputs are captured in one go at the acknowledge bit
                            txSh_d = gpiSync_q;
                        end else begin
                            state_d = i2c_gpio_pkg::ST_IGNORE;
                        end
                    end
                end
                i2c_gpio_pkg::ST_ADDR_ACK: begin
                    // The first read bit goes out at the fall that ends the acknowledge
                    if (sclFall) begin
                        cnt_d = i2c_gpio_pkg::CNT_ZERO;
                        if (rw_q == i2c_gpio_pkg::RW_READ) begin
                            state_d = i2c_gpio_pkg::ST_RD_DATA;
                            drvLow_d = ~txSh_q[GP_W-1];
                        end else begin
                            state_d = i2c_gpio_pkg::ST_WR_DATA;
                            drvLow_d = 1'b0;
                        end
                    end
                end
                i2c_gpio_pkg::ST_WR_DATA: begin
                    if (sclRise) begin
                        rxSh_d = {rxSh_q[GP_W-2:0], sdaSync_q};
                        cnt_d = cnt_q + i2c_gpio_pkg::CNT_ONE;
                    end
                    if (sclFall && cnt_q == i2c_gpio_pkg::BYTE_BITS) begin
                        state_d = i2c_gpio_pkg::ST_WR_ACK;
                        drvLow_d = 1'b1;
                        wrByte_d = rxSh_q;
                        wrTgl_d = ~wrTgl_q;
                    end
                end
                i2c_gpio_pkg::ST_WR_ACK: begin
                    // Further bytes keep updating the outputs until stop or restart
                    if (sclFall) begin
                        state_d = i2c_gpio_pkg::ST_WR_DATA;
                        cnt_d = i2c_gpio_pkg::CNT_ZERO;
                        drvLow_d = 1'b0;
                    end
                end
                i2c_gpio_pkg::ST_RD_DATA: begin
                    if (sclRise) begin
                        cnt_d = cnt_q + i2c_gpio_pkg::CNT_ONE;
                    end
                    if (sclFall) begin
                        if (cnt_q == i2c_gpio_pkg::BYTE_BITS) begin
                            // Release so the master can acknowledge
                            state_d = i2c_gpio_pkg::ST_RD_ACK;
                            drvLow_d = 1'b0;
                        end else begin
                            txSh_d = {txSh_q[GP_W-2:0], 1'b0};
                            drvLow_d = ~txSh_q[GP_W-2];
                        end
                    end
                end
                i2c_gpio_pkg::ST_RD_ACK: begin
                    if (sclRise) begin
                        if (sdaSync_q == i2c_gpio_pkg::ACK_LEVEL) begin
                            txSh_d = gpiSync_q;
                        end else begin
                            // A missing acknowledge means the master is done reading
                            state_d = i2c_gpio_pkg::ST_IGNORE;
                        end
                    end
                    if (sclFall) begin
                        state_d = i2c_gpio_pkg::ST_RD_DATA;
                        cnt_d = i2c_gpio_pkg::CNT_ZERO;
                        drvLow_d = ~txSh_q[GP_W-1];
                    end
                end
            endcase
        end
    end

    // Registers with the link reset; outside reset every next value comes from the block above
    always_ff @(posedge linkClk) begin
        if (linkRst_q) begin
            state_q <= i2c_gpio_pkg::ST_IDLE;
            cnt_q <= i2c_gpio_pkg::CNT_ZERO;
            rxSh_q <= i2c_gpio_pkg::BYTE_ZERO;
            txSh_q <= i2c_gpio_pkg::BYTE_ZERO;
            rw_q <= 1'b0;
            drvLow_q <= 1'b0;
            wrByte_q <= i2c_gpio_pkg::GPO_RESET;
            wrTgl_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rxSh_q <= rxSh_d;
            txSh_q <= txSh_d;
            rw_q <= rw_d;
            drvLow_q <= drvLow_d;
            wrByte_q <= wrByte_d;
            wrTgl_q <= wrTgl_d;
        end
    end

    // ==========================================================
    // Open-drain pins
    // Only ever pull low or let go; the clock line is never stretched
    assign sdaOut = i2c_gpio_pkg::PIN_LOW;
    assign sdaOeN = ~drvLow_q;
    assign sclOut = i2c_gpio_pkg::PIN_LOW;
    assign sclOeN = i2c_gpio_pkg::OE_RELEASED;

    // ==========================================================
    // Output byte into the system clock domain
    // wrByte_q holds a whole bus byte time after each toggle, ample for the crossing
    // All output bits change on one system clock edge, never bit by bit
    cdc_word_toggle #(
        .W(GP_W)
    ) u_cdc_word_toggle (
        .clk(clk),
        .sys_rst(sys_rst),
        .srcToggle(wrTgl_q),
        .srcWord(wrByte_q),
        .dstWord(gpOut)
    );

endmodule

`default_nettype wire

// file: verif/i2c_gpio_expander_asserts.sv
// Port checker for the two-wire GPIO expander
`timescale 1ns/1ns
`default_nettype none

module i2c_gpio_expander_checker #(
    parameter int GP_W = 8
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic sclIn, // Bus clock level
    input wire logic sclOut, // Bus clock drive value
    input wire logic sclOeN, // Bus clock enable
    input wire logic sdaOut, // Bus data drive value
    input wire logic sdaOeN, // Bus data enable
    input wire logic [GP_W-1:0] gpOut // Output pins
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Pins only ever pull low, and the clock is never stretched
    chk_scl_released: assert property (sclOeN)
        else $error("bus clock enable active");
    chk_drive_zero: assert property (!sclOut && !sdaOut)
        else $error("drive value not low");
    chk_reset_gpo: assert property (disable iff (1'b0) sys_rst |=> gpOut == '0)
        else $error("outputs not cleared by reset");
    // Outputs move only during the slave acknowledge, all at once
    chk_gpo_in_ack: assert property (gpOut != $past(gpOut) |-> !sdaOeN && !sclIn)
        else $error("outputs changed outside acknowledge");
    chk_gpo_whole: assert property (gpOut != $past(gpOut) |=> $stable(gpOut) [*8])
        else $error("outputs changed bit by bit");
    // Slave data moves well after the clock fall, never with clock high
    chk_sda_hold: assert property ($changed(sdaOeN) |-> !sclIn && !$past(sclIn, 40))
        else $error("data changed near clock high");
    chk_bit_stands: assert property ($rose(sclIn) && !sdaOeN |-> (!sdaOeN) [*8])
        else $error("driven bit not held");
    chk_ack_low: assert property ($fell(sdaOeN) |-> !sclIn [*8])
        else $error("acknowledge started with clock high");
    cover property ($fell(sdaOeN));
    cover property (gpOut != $past(gpOut));
    cover property ($rose(sclIn) && !sdaOeN);
endmodule

bind i2c_gpio_expander i2c_gpio_expander_checker #(.GP_W(GP_W)) u_chk (.clk(clk),
    .sys_rst(sys_rst), .sclIn(sclIn), .sclOut(sclOut), .sclOeN(sclOeN), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .gpOut(gpOut));

`default_nettype wire

// file: verif/i2c_host_model.sv
// Bus master model driving the clock and data lines of the expander
`timescale 1ns/1ns
`default_nettype none

module i2c_host_model #(
    parameter int Q = 160
) (
    input wire logic clk, // Timing reference
    input wire logic sdaOeN, // Slave data enable
    input wire logic sdaOut, // Slave data drive value
    output logic sclLine, // Bus clock wire
    output logic sdaLine // Bus data wire
);
    logic mLow = 1'b0;
    logic sclQ = 1'b1;

    // Pull-up wire: low while either party pulls, clock idles high
    assign sdaLine = !(mLow || (!sdaOeN && !sdaOut));
    assign sclLine = sclQ;

    // ==========================================================
    // Quarter bit; 640 ns keeps both clock phases above five link periods
    task automatic qtr();
        repeat (Q) @(posedge clk);
        #1;
    endtask

    // Works from idle and as a repeated start mid transfer
    task automatic start_c();
        mLow = 1'b0;
        qtr();
        sclQ = 1'b1;
        qtr();
        mLow = 1'b1;
        qtr();
        sclQ = 1'b0;
        qtr();
    endtask

    task automatic stop_c();
        mLow = 1'b1;
        qtr();
        sclQ = 1'b1;
        qtr();
        mLow = 1'b0;
        qtr();
    endtask

    // Data set a quarter after the fall, sampled mid high
    task automatic bit_x(input logic b, output logic r);
        mLow = !b;
        qtr();
        sclQ = 1'b1;
        qtr();
        r = sdaLine;
        qtr();
        sclQ = 1'b0;
        qtr();
    endtask

    task automatic byte_x(input logic [7:0] b, input logic ackIn, output logic [7:0] r,
                          output logic ackOut);
        for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
        bit_x(ackIn, ackOut);
    endtask
endmodule

`default_nettype wire

// file: verif/tb_i2c_gpio_expander.sv
// Self-checking bench for the two-wire GPIO expander
`timescale 1ns/1ns
`default_nettype none

module tb_i2c_gpio_expander;
    localparam int Q = 160;
    logic clk = 1'b0;
    logic linkClk = 1'b0;
    logic sys_rst = 1'b1;
    logic sclLine, sdaLine, sclOut, sclOeN, sdaOut, sdaOeN, ack;
    logic [7:0] gpIn = 8'h00;
    logic [7:0] gpOut, rd, v1, v2;
    int miscompares = 0;
    int checks = 0;
    int expGpo = 0;
    logic [7:0] expRd[$];

    // Clocks; the link clock has an odd offset, yet its rising edges still meet those of clk every 500 ns
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        #37;
        forever begin
            #62 linkClk = ~linkClk;
            #63 linkClk = ~linkClk;
        end
    end

    i2c_gpio_expander u_i2c_gpio_expander (.clk(clk), .sys_rst(sys_rst), .linkClk(linkClk),
        .sclIn(sclLine), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .gpIn(gpIn), .gpOut(gpOut));
    i2c_host_model #(.Q(Q)) u_i2c_host_model (.clk(clk), .sdaOeN(sdaOeN), .sdaOut(sdaOut),
        .sclLine(sclLine), .sdaLine(sdaLine));

    // ==========================================================
    // Comparison, verdict and transfer helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic addr_x(input logic [6:0] a, input logic rw, input logic match);
        u_i2c_host_model.start_c();
        u_i2c_host_model.byte_x({a, rw}, 1'b1, rd, ack);
        check("address ack", {7'h00, ack}, {7'h00, !match});
    endtask

    // Random byte; the model only moves its outputs when addressed
    task automatic wr_byte(input logic match);
        logic [7:0] v;
        v = 8'($urandom);
        u_i2c_host_model.byte_x(v, 1'b1, rd, ack);
        if (match) expGpo = v;
        check("write ack", {7'h00, ack}, {7'h00, !match});
        check("gpOut", gpOut, expGpo[7:0]);
    endtask

    // Hang guard, about a fifth above the expected run
    initial begin
        repeat (99000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        stop_test();
    end

    // Reset is held past four link periods so the link side sees it
    initial begin
        void'($urandom(21161));
        repeat (160) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (160) @(posedge clk);
        #1;
        addr_x(7'h00, 1'b0, 1'b1);
        wr_byte(1'b1);
        wr_byte(1'b1);
        v1 = 8'($urandom);
        v2 = 8'($urandom);
        gpIn = v1;
        expRd.push_back(v1);
        expRd.push_back(v2);
        addr_x(7'h00, 1'b1, 1'b1);
        fork
            u_i2c_host_model.byte_x(8'hFF, 1'b0, rd, ack);
            begin
                repeat (8 * Q) @(posedge clk);
                #1 gpIn = v2;
            end
        join
        check("read byte 0", rd, expRd.pop_front());
        u_i2c_host_model.byte_x(8'hFF, 1'b1, rd, ack);
        check("read byte 1", rd, expRd.pop_front());
        check("gpOut in read", gpOut, expGpo[7:0]);
        u_i2c_host_model.stop_c();
        $display("test write_read done");
        addr_x(7'h21, 1'b0, 1'b0);
        wr_byte(1'b0);
        u_i2c_host_model.stop_c();
        $display("test mismatch done");
        addr_x(7'h00, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++) u_i2c_host_model.bit_x(1'($urandom), rd[0]);
        u_i2c_host_model.stop_c();
        check("gpOut after abort", gpOut, expGpo[7:0]);
        addr_x(7'h00, 1'b0, 1'b1);
        wr_byte(1'b1);
        // Repeated start straight out of a write turns the bus round to a read
        gpIn = 8'($urandom);
        expRd.push_back(gpIn);
        addr_x(7'h00, 1'b1, 1'b1);
        u_i2c_host_model.byte_x(8'hFF, 1'b1, rd, ack);
        check("read after restart", rd, expRd.pop_front());
        check("gpOut after restart", gpOut, expGpo[7:0]);
        u_i2c_host_model.stop_c();
        $display("test abort done");
        stop_test();
    end
endmodule

`default_nettype wire
